// *** logic/jie_top.sv ***
// execute logic for jump and two increment instructions
// assumes the fetch path presents the next word on INSTR_WORD at each Q1 and the
// register file answers RF_RDATA combinationally for RF_ADDR during Q2
//
// Overview of operation
// - the jump loads its 20-bit literal into program counter bits 20 to 1.
// - the jump takes two cycles, the second being a no-operation refill.
// - the plain increment adds one and updates carry, digit carry, negative, overflow and zero.
// - both increments write to the working register when d is 0 and back to the file when d is 1.
// - with a equal to 0 the operand is taken from the fixed access bank, except in the indexed case below.
// - with a equal to 1 the operand address is the bank select value joined with the file field.
// - with the extended set on, a at 0 and f at most 95, the operand is indexed off the literal base.
// - the skip increment changes no flags and turns the next cycle into a no-operation on a zero result.
`timescale 1ns/10ps
`default_nettype none
module jie_top
(
    input  wire logic        SYS_CLK,
    input  wire logic        RESET,
    input  wire logic [15:0] INSTR_WORD,
    input  wire logic [3:0]  BANK_SELECT_REGISTER,
    input  wire logic [11:0] INDEX_BASE,
    input  wire logic        EXT_SET_EN,
    input  wire logic [7:0]  RF_RDATA,
    output var  logic [11:0] RF_ADDR,
    output var  logic        RF_WE,
    output var  logic [7:0]  RF_WDATA,
    output var  logic        W_WE,
    output var  logic [7:0]  W_WDATA,
    output var  logic [20:0] PC,
    output var  logic        CARRY_FLAG,
    output var  logic        DIGIT_CARRY_FLAG,
    output var  logic        ZERO_FLAG,
    output var  logic        OVERFLOW_FLAG,
    output var  logic        NEGATIVE_FLAG,
    output var  logic        NOP_CYCLE,
    output var  logic [1:0]  PHASE
);
    jie_pkg::jie_phase_t phase_reg;
    jie_pkg::jie_mode_t  mode_reg;
    logic [15:0]         ir_reg;
    logic [7:0]          jump_lo_reg;
    logic [7:0]          opnd_reg;
    logic [11:0]         addr_reg;
    logic                is_inc_reg;
    logic                is_sz_reg;
    logic [7:0]          alu_result;
    logic [4:0]          alu_flags;
    logic                jump_exec;

    // operand address for byte-oriented ops
    function automatic logic [11:0] jie_fsel(input logic [15:0] iw, input logic [3:0] bank_select_register,
                                             input logic [11:0] base, input logic ext);
        logic [7:0] f;
        f = iw[7:0];
        if (iw[jie_pkg::A_BIT])
            jie_fsel = {bank_select_register, f};
        else if (ext && (f <= jie_pkg::INDEX_LIMIT))
            jie_fsel = base + {4'h0, f};
        else if (f < jie_pkg::ACCESS_SPLIT)
            jie_fsel = {jie_pkg::ACCESS_LO_BNK, f};
        else
            jie_fsel = {jie_pkg::ACCESS_HI_BNK, f};
    endfunction

    function automatic logic jie_is(input logic [15:0] iw, input logic [5:0] op);
        jie_is = (iw[15:jie_pkg::OPC_LSB] == op);
    endfunction

    function automatic logic jie_is_jump(input logic [15:0] iw);
        jie_is_jump = (iw[15:8] == jie_pkg::OP_JUMP_HI);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
            phase_reg <= jie_pkg::JIE_Q1;
        else
            phase_reg <= jie_pkg::jie_phase_t'(phase_reg + 2'b01);
    end

    assign PHASE     = phase_reg;
    assign NOP_CYCLE = (mode_reg != jie_pkg::JIE_EXEC);

    // a jump counts only in an executing cycle, so a discarded word never redirects
    assign jump_exec = (mode_reg == jie_pkg::JIE_EXEC) && jie_is_jump(ir_reg);

    ////////////////////////////////////////////////////////////////////////////
    // decode and mode sequencing
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            ir_reg      <= 16'h0000;
            is_inc_reg  <= 1'b0;
            is_sz_reg   <= 1'b0;
            mode_reg    <= jie_pkg::JIE_EXEC;
            jump_lo_reg <= 8'h00;
        end
        else
        begin
            unique case (phase_reg)
                jie_pkg::JIE_Q1:
                begin
                    // words that arrive in a no-operation cycle are dropped here,
                    // so a discarded instruction can never start a read or a write
                    ir_reg     <= INSTR_WORD;
                    is_inc_reg <= (mode_reg == jie_pkg::JIE_EXEC) &&
                                  (jie_is(INSTR_WORD, jie_pkg::OP_INC) || jie_is(INSTR_WORD, jie_pkg::OP_INCSZ));
                    is_sz_reg  <= (mode_reg == jie_pkg::JIE_EXEC) && jie_is(INSTR_WORD, jie_pkg::OP_INCSZ);
                end
                jie_pkg::JIE_Q2:
                begin
                    if (jump_exec)
                        jump_lo_reg <= ir_reg[7:0];
                end
                jie_pkg::JIE_Q3:
                begin
                end
                jie_pkg::JIE_Q4:
                begin
                    if (jump_exec)
                        mode_reg <= jie_pkg::JIE_JUMP2;
                    // note: only one cycle is skipped, which covers a two-word jump, as its second
                    // word arrives in Q4 of the same cycle and is never decoded on its own
                    else if (mode_reg == jie_pkg::JIE_EXEC && is_sz_reg && alu_result == 8'h00)
                        mode_reg <= jie_pkg::JIE_FLUSH;
                    else
                        mode_reg <= jie_pkg::JIE_EXEC;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // program counter: steps each cycle, jump writes in Q4 of its first cycle
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
            PC <= jie_pkg::PC_RESET;
        else if (phase_reg == jie_pkg::JIE_Q4)
        begin
            if (jump_exec)
                PC <= {INSTR_WORD[11:0], jump_lo_reg, 1'b0};
            else
                PC <= PC + jie_pkg::PC_STEP;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // operand read in Q2
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            addr_reg <= 12'h000;
            opnd_reg <= 8'h00;
        end
        else if (phase_reg == jie_pkg::JIE_Q2 && is_inc_reg)
        begin
            addr_reg <= jie_fsel(ir_reg, BANK_SELECT_REGISTER, INDEX_BASE, EXT_SET_EN);
            opnd_reg <= RF_RDATA;
        end
    end

    // combinational in Q2 so the file answers within the phase; held afterwards
    // so the write-back in the next Q1 lands on the same cell
    assign RF_ADDR = (phase_reg == jie_pkg::JIE_Q2) ?
                     jie_fsel(ir_reg, BANK_SELECT_REGISTER, INDEX_BASE, EXT_SET_EN) : addr_reg;

    // the incrementer registers its result, so Q4 sees settled data and flags
    jie_alu u_alu
    (
        .clk     (SYS_CLK),
        .rst     (RESET),
        .load    (phase_reg == jie_pkg::JIE_Q3 && is_inc_reg),
        .operand (opnd_reg),
        .result  (alu_result),
        .flags   (alu_flags)
    );

    ////////////////////////////////////////////////////////////////////////////
    // destination write and flags in Q4; strobes are one clock wide
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            RF_WE    <= 1'b0;
            W_WE     <= 1'b0;
            RF_WDATA <= 8'h00;
            W_WDATA  <= 8'h00;
        end
        else
        begin
            RF_WE    <= (phase_reg == jie_pkg::JIE_Q4) && is_inc_reg && ir_reg[jie_pkg::D_BIT];
            W_WE     <= (phase_reg == jie_pkg::JIE_Q4) && is_inc_reg && !ir_reg[jie_pkg::D_BIT];
            RF_WDATA <= alu_result;
            W_WDATA  <= alu_result;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status flags: the skip increment leaves them alone, so a loop counter
    // can be stepped without losing the outcome of an earlier comparison
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            CARRY_FLAG       <= 1'b0;
            DIGIT_CARRY_FLAG <= 1'b0;
            ZERO_FLAG        <= 1'b0;
            OVERFLOW_FLAG    <= 1'b0;
            NEGATIVE_FLAG    <= 1'b0;
        end
        else if (phase_reg == jie_pkg::JIE_Q4 && is_inc_reg && !is_sz_reg)
        begin
            {CARRY_FLAG, DIGIT_CARRY_FLAG, ZERO_FLAG, OVERFLOW_FLAG, NEGATIVE_FLAG} <= alu_flags;
        end
    end
endmodule
`default_nettype wire

// *** logic/jie_pkg.sv ***
// package for the jump and increment execute block
// assumes a core that feeds one 16-bit instruction word per four-phase cycle
package jie_pkg;
    localparam int          INSTR_W       = 16;
    localparam int          PC_W          = 21;
    localparam int          ADDR_W        = 12;
    localparam logic [7:0]  OP_JUMP_HI    = 8'hef;
    localparam logic [3:0]  OP_JUMP_W2    = 4'hf;
    localparam logic [5:0]  OP_INC        = 6'h0a;
    localparam logic [5:0]  OP_INCSZ      = 6'h0f;
    localparam int          OPC_LSB       = 10;
    localparam int          D_BIT         = 9;
    localparam int          A_BIT         = 8;
    localparam logic [7:0]  INDEX_LIMIT   = 8'h5f;
    localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
    localparam logic [3:0]  ACCESS_HI_BNK = 4'hf;
    localparam logic [3:0]  ACCESS_LO_BNK = 4'h0;
    localparam logic [20:0] PC_RESET      = 21'h000000;
    localparam logic [20:0] PC_STEP       = 21'h000002;

    typedef enum logic [1:0]
    {
        JIE_Q1 = 2'b00,
        JIE_Q2 = 2'b01,
        JIE_Q3 = 2'b10,
        JIE_Q4 = 2'b11
    } jie_phase_t;

    typedef enum logic [1:0]
    {
        JIE_EXEC   = 2'b00,
        JIE_JUMP2  = 2'b01,
        JIE_FLUSH  = 2'b10
    } jie_mode_t;
endpackage

// *** logic/jie_alu.sv ***
// incrementer with flag generation for the jump and increment execute block
// assumes a registered operand; result and flags are registered here
`timescale 1ns/10ps
`default_nettype none
module jie_alu
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       load,
    input  wire logic [7:0] operand,
    output var  logic [7:0] result,
    output var  logic [4:0] flags
);
    logic [8:0] sum;
    assign sum = {1'b0, operand} + 9'h001;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            result <= 8'h00;
            flags  <= 5'h00;
        end
        else if (load)
        begin
            result <= sum[7:0];
            // order: carry, digit carry, zero, overflow, negative
            flags  <= {sum[8], (operand[3:0] == 4'hf), (sum[7:0] == 8'h00),
                       (operand == 8'h7f), sum[7]};
        end
    end
endmodule
`default_nettype wire

// *** bench/jie_rf_model.sv ***
// register file stand-in for the execute block
// assumes reads answer at once and a write lands at the edge after the strobe
`timescale 1ns/10ps
`default_nettype none
module jie_rf_model
(
    input  wire logic        clk,
    input  wire logic [11:0] addr,
    input  wire logic        we,
    input  wire logic [7:0]  wdata,
    output var  logic [7:0]  rdata
);
    // unwritten cells read unknown, so a stray address shows up
    logic [7:0] mem [4096];
    assign rdata = mem[addr];
    always @(posedge clk) if (we) mem[addr] <= wdata;
endmodule
`default_nettype wire

// *** bench/jie_top_monitor.sv ***
// assertions on the ports of the execute block
// assumes a bind onto jie_top and one clock domain
`timescale 1ns/10ps
`default_nettype none
module jie_top_monitor
(
    input wire logic        SYS_CLK,
    input wire logic        RESET,
    input wire logic [15:0] INSTR_WORD,
    input wire logic [3:0]  BANK_SELECT_REGISTER,
    input wire logic [11:0] INDEX_BASE,
    input wire logic        EXT_SET_EN,
    input wire logic [7:0]  RF_RDATA,
    input wire logic [11:0] RF_ADDR,
    input wire logic        RF_WE,
    input wire logic [7:0]  RF_WDATA,
    input wire logic        W_WE,
    input wire logic [7:0]  W_WDATA,
    input wire logic [20:0] PC,
    input wire logic        CARRY_FLAG,
    input wire logic        DIGIT_CARRY_FLAG,
    input wire logic        ZERO_FLAG,
    input wire logic        OVERFLOW_FLAG,
    input wire logic        NEGATIVE_FLAG,
    input wire logic        NOP_CYCLE,
    input wire logic [1:0]  PHASE
);
    logic       take, inc_take, skz_take, any_take, jmp_take, idx;
    logic [7:0] fld;
    logic [4:0] flg;
    assign take = PHASE == 2'h0 && !NOP_CYCLE;
    assign fld = INSTR_WORD[7:0];
    assign flg = {CARRY_FLAG, DIGIT_CARRY_FLAG, ZERO_FLAG, OVERFLOW_FLAG, NEGATIVE_FLAG};
    assign inc_take = take && INSTR_WORD[15:10] == jie_pkg::OP_INC;
    assign skz_take = take && INSTR_WORD[15:10] == jie_pkg::OP_INCSZ;
    assign any_take = inc_take || skz_take;
    assign jmp_take = take && INSTR_WORD[15:8] == jie_pkg::OP_JUMP_HI;
    assign idx = EXT_SET_EN && fld <= jie_pkg::INDEX_LIMIT;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    sequence s_jump_pair; jmp_take ##3 INSTR_WORD[15:12] == jie_pkg::OP_JUMP_W2; endsequence
    sequence s_zero_skip; skz_take ##1 RF_RDATA == 8'hff; endsequence
    sequence s_wrap_inc; inc_take ##1 RF_RDATA == 8'hff; endsequence
    chk_jump_target: assert property (s_jump_pair |=> PC == {$past(INSTR_WORD[11:0]), $past(fld, 4), 1'b0})
        else $error("jump target wrong");
    chk_jump_refill: assert property (jmp_take |-> ##4 NOP_CYCLE [*4])
        else $error("jump refill cycle missing");
    chk_skip_nop: assert property (s_zero_skip |-> ##3 NOP_CYCLE [*4])
        else $error("skip cycle missing");
    chk_skip_flags: assert property (skz_take |-> ##4 $stable(flg))
        else $error("skip increment moved flags");
    chk_inc_flags: assert property (s_wrap_inc |-> ##3 flg == 5'h1c)
        else $error("wrap flags wrong");
    chk_write_dest: assert property (any_take |-> ##4 RF_WE == $past(INSTR_WORD[9], 4) && W_WE != RF_WE)
        else $error("destination strobe wrong");
    chk_bank_addr: assert property (any_take && INSTR_WORD[8] |=> RF_ADDR == {BANK_SELECT_REGISTER, $past(fld)})
        else $error("banked address wrong");
    chk_access_bank: assert property (any_take && !INSTR_WORD[8] && !idx |=>
        RF_ADDR == {($past(fld) < 8'h60) ? 4'h0 : 4'hf, $past(fld)}) else $error("access bank address wrong");
    chk_indexed_addr: assert property (any_take && !INSTR_WORD[8] && idx |=> RF_ADDR == INDEX_BASE + {4'h0, $past(fld)})
        else $error("indexed address wrong");
endmodule
`default_nettype wire

// *** bench/jie_top_test.sv ***
// self-checking bench for the execute block
// assumes the register file stand-in answers reads in the same cycle
`timescale 1ns/10ps
`default_nettype none
module jie_top_test;
    logic        sys_clk = 1'b0, rst = 1'b1, ext_en = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [11:0] index_base = 12'h200, rf_addr;
    logic [7:0]  rf_rdata, rf_wdata, w_wdata;
    logic        rf_we, w_we, nop_cycle, c_f, dc_f, z_f, ov_f, n_f;
    logic [20:0] pc;
    logic [1:0]  phase;
    logic [3:0]  bank_sel = 4'h3;
    int          n_errors = 0, num_checks = 0;
    wire  [4:0]  flg = {c_f, dc_f, z_f, ov_f, n_f};
    always #25 sys_clk = ~sys_clk;
    jie_top dut_u (.SYS_CLK(sys_clk), .RESET(rst), .INSTR_WORD(instr_word), .BANK_SELECT_REGISTER(bank_sel),
        .INDEX_BASE(index_base), .EXT_SET_EN(ext_en), .RF_RDATA(rf_rdata), .RF_ADDR(rf_addr), .RF_WE(rf_we),
        .RF_WDATA(rf_wdata), .W_WE(w_we), .W_WDATA(w_wdata), .PC(pc), .CARRY_FLAG(c_f), .DIGIT_CARRY_FLAG(dc_f),
        .ZERO_FLAG(z_f), .OVERFLOW_FLAG(ov_f), .NEGATIVE_FLAG(n_f), .NOP_CYCLE(nop_cycle), .PHASE(phase));
    jie_rf_model rf_u (.clk(sys_clk), .addr(rf_addr), .we(rf_we), .wdata(rf_wdata), .rdata(rf_rdata));
    task automatic wrap_up;
        if (n_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [20:0] got, input logic [20:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    // presents w1 in Q1 and w2 in Q4, returns just after the edge closing Q4
    task automatic issue(input logic [15:0] w1, input logic [15:0] w2);
        do
        begin
            @(posedge sys_clk);
            #1;
        end while (phase !== 2'h3);
        @(posedge sys_clk) instr_word <= w1;
        @(posedge sys_clk) instr_word <= 16'h0000;
        repeat (2) @(posedge sys_clk);
        instr_word <= w2;
        @(posedge sys_clk) instr_word <= 16'h0000;
        #1;
    endtask
    task automatic t_increments;
        rf_u.mem[12'h312] = 8'h7f;
        issue({jie_pkg::OP_INC, 2'b11, 8'h12}, 16'h0000);
        check(21'(rf_we), 21'h1);
        check(21'(w_we), 21'h0);
        check(21'(rf_wdata), 21'h80);
        check(21'(flg), 21'h0b);
        rf_u.mem[12'hf70] = 8'hff;
        issue({jie_pkg::OP_INC, 2'b00, 8'h70}, 16'h0000);
        check(21'({w_we, rf_we}), 21'h2);
        check(21'(w_wdata), 21'h00);
        check(21'(flg), 21'h1c);
    endtask
    task automatic t_skip;
        rf_u.mem[12'h312] = 8'hff;
        issue({jie_pkg::OP_INCSZ, 2'b11, 8'h12}, 16'h0000);
        check(21'({nop_cycle, rf_we, rf_wdata}), 21'h300);
        check(21'(flg), 21'h1c);
        rf_u.mem[12'h513] = 8'h05;
        @(posedge sys_clk) bank_sel <= 4'h5;
        issue({jie_pkg::OP_INCSZ, 2'b01, 8'h13}, 16'h0000);
        check(21'({nop_cycle, w_we, w_wdata}), 21'h106);
        check(21'(flg), 21'h1c);
    endtask
    task automatic t_indexed;
        rf_u.mem[12'h205] = 8'h10;
        @(posedge sys_clk) ext_en <= 1'b1;
        issue({jie_pkg::OP_INC, 2'b10, 8'h05}, 16'h0000);
        check(21'({rf_we, rf_wdata}), 21'h111);
        @(posedge sys_clk) #1;
        check(21'(rf_u.mem[12'h205]), 21'h11);
    endtask
    task automatic t_jump;
        issue({jie_pkg::OP_JUMP_HI, 8'hde}, {jie_pkg::OP_JUMP_W2, 12'habc});
        check(pc, {20'habcde, 1'b0});
        check(21'(nop_cycle), 21'h1);
        repeat (4) @(posedge sys_clk);
        #1;
        check(21'(nop_cycle), 21'h0);
        check(pc, {20'habcdf, 1'b0});
    endtask
    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        t_increments();
        t_skip();
        t_indexed();
        t_jump();
        wrap_up();
    end
    initial
    begin
        #100000;
        n_errors++;
        wrap_up();
    end
endmodule
bind jie_top jie_top_monitor mon_u (.SYS_CLK(SYS_CLK), .RESET(RESET), .INSTR_WORD(INSTR_WORD),
    .BANK_SELECT_REGISTER(BANK_SELECT_REGISTER), .INDEX_BASE(INDEX_BASE), .EXT_SET_EN(EXT_SET_EN),
    .RF_RDATA(RF_RDATA), .RF_ADDR(RF_ADDR), .RF_WE(RF_WE), .RF_WDATA(RF_WDATA), .W_WE(W_WE), .W_WDATA(W_WDATA),
    .PC(PC), .CARRY_FLAG(CARRY_FLAG), .DIGIT_CARRY_FLAG(DIGIT_CARRY_FLAG), .ZERO_FLAG(ZERO_FLAG),
    .OVERFLOW_FLAG(OVERFLOW_FLAG), .NEGATIVE_FLAG(NEGATIVE_FLAG), .NOP_CYCLE(NOP_CYCLE), .PHASE(PHASE));
`default_nettype wire
